/* File: rtl/ipc_pin_ctrl.sv */
`timescale 1ns/1ps
`include "ipc_cfg.svh"
module ipc_pin_ctrl (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_chip_reset_n,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata_q,
    input wire logic [7:0] i_gen_inputs,
    output logic [7:0] o_gen_outputs_q,
    input wire logic i_bus_power_sense_in,
    input wire logic i_attach_det,
    input wire logic i_bus_activity,
    input wire logic i_sof_wave,
    input wire logic i_core_irq_req,
    output logic o_irq_pin_q,
    output logic o_irq_oe_q,
    output logic o_aux_out_q,
    output logic o_aux_oe_q,
    output logic o_dplus_pullup_q,
    output logic o_dplus_pulldown_en_q,
    output logic o_dminus_pulldown_en_q
);
    import ipc_pkg::*;

    // synchronised pin inputs
    logic [10:0] sync_q;
    logic [7:0] gen_in_s; // general inputs
    logic bus_power_detected; // comparator output
    logic attach_s; // attach sense from the line
    logic chip_reset_n_s; // chip reset pin, low active

    // software visible registers
    logic [7:0] bus_ctl_q; // survives chip reset
    logic [7:0] cpu_ctl_q;
    logic [7:0] pin_cfg_q; // survives chip reset
    logic [7:0] mode_q;
    logic [7:0] gen_out_q;
    logic [7:0] in_flags_q;
    logic [7:0] in_en_q;
    logic [7:0] in_pol_q;
    logic [7:0] host_irq_q;
    logic [7:0] host_ien_q;

    // internal state
    logic [7:0] gen_in_prev_q; // last sampled inputs, for edges
    logic attach_prev_q; // last attach sense
    logic operate_q; // ready to operate indicator
    logic chip_rst; // chip reset active
    logic [7:0] in_edge; // selected edge seen per input
    logic attach_chg; // attach state changed
    logic input_irq_out; // any enabled input flag
    logic split_on; // inputs routed to aux pin
    logic aux_irq_pin; // aux interrupt driver pin
    logic aux_irq_oe; // aux interrupt driver enable
    ipc_aux_sel_t aux_sel; // aux mux select
    logic [2:0] main_req; // request sources of the main pin
    logic [0:0] aux_req; // request source of the aux pin
    logic wr_sel; // helper for write decode
    logic [7:0] rd_mux; // addressed register value

    // three pins and eight general inputs cross into the clock domain
    ipc_sync #(.W(11)) u_sync (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_async({i_chip_reset_n, i_attach_det, i_bus_power_sense_in, i_gen_inputs}),
        .o_sync_q(sync_q)
    );

    assign gen_in_s = sync_q[7:0];
    assign bus_power_detected = sync_q[8];
    assign attach_s = sync_q[9];
    assign chip_reset_n_s = sync_q[10];
    assign chip_rst = ~chip_reset_n_s;
    assign wr_sel = i_reg_wr & ~chip_rst;

    // per-input edge select: 1 rising, 0 falling
    assign in_edge = (gen_in_s & ~gen_in_prev_q & in_pol_q)
                   | (~gen_in_s & gen_in_prev_q & ~in_pol_q);
    // attach or detach in host mode
    assign attach_chg = (attach_s ^ attach_prev_q) & mode_q[`IPC_BIT_HOST];
    assign input_irq_out = |(in_flags_q & in_en_q);
    assign aux_sel = {pin_cfg_q[`IPC_BIT_AUX_SEL_HI], pin_cfg_q[`IPC_BIT_AUX_SEL_LO]};
    // split only with select code 10
    assign split_on = mode_q[`IPC_BIT_SPLIT_IRQ] & (aux_sel == 2'h2);
    assign main_req = {input_irq_out & ~split_on,
                       |(host_irq_q & host_ien_q),
                       i_core_irq_req};
    assign aux_req = input_irq_out & split_on;

    // shared settings for both interrupt pins
    ipc_irq_cfg_if irq_cfg ();
    assign irq_cfg.enable = cpu_ctl_q[`IPC_BIT_IRQ_OUT_EN];
    assign irq_cfg.level_mode = pin_cfg_q[`IPC_BIT_LEVEL_MODE];
    assign irq_cfg.active_high = pin_cfg_q[`IPC_BIT_ACTIVE_HIGH];
    assign irq_cfg.width_sel = {cpu_ctl_q[`IPC_BIT_WIDTH_HI], cpu_ctl_q[`IPC_BIT_WIDTH_LO]};

    // main interrupt pin; level mode never looks at polarity
    // pulses on new or remaining requests
    ipc_irq_pin_drv #(.N(3)) u_main_irq (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_soft_rst(chip_rst),
        .cfg(irq_cfg),
        .i_req(main_req),
        .o_pin_q(o_irq_pin_q),
        .o_oe_q(o_irq_oe_q)
    );

    ipc_irq_pin_drv #(.N(1)) u_aux_irq (
        .i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst),
        .i_soft_rst(chip_rst),
        .cfg(irq_cfg),
        .i_req(aux_req),
        .o_pin_q(aux_irq_pin),
        .o_oe_q(aux_irq_oe)
    );

    // all state below on the rising edge of the one clock
    // registers that survive chip reset: bus control and pin config
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            bus_ctl_q <= `IPC_RST_BYTE;
            pin_cfg_q <= `IPC_RST_BYTE;
        end else if (i_reg_wr) begin
            // written even while chip reset holds the rest
            if (i_reg_addr == `IPC_REG_BUS_CTL) begin
                bus_ctl_q <= i_reg_wdata;
            end
            if (i_reg_addr == `IPC_REG_PIN_CFG) begin
                pin_cfg_q <= i_reg_wdata;
            end
        end
    end

    // plain control registers, cleared by chip reset
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            cpu_ctl_q <= `IPC_RST_BYTE;
            mode_q <= `IPC_RST_BYTE;
            in_en_q <= `IPC_RST_BYTE;
            in_pol_q <= `IPC_RST_BYTE;
            host_ien_q <= `IPC_RST_BYTE;
            gen_out_q <= `IPC_RST_BYTE;
        end else if (chip_rst) begin
            cpu_ctl_q <= `IPC_RST_BYTE;
            mode_q <= `IPC_RST_BYTE;
            in_en_q <= `IPC_RST_BYTE;
            in_pol_q <= `IPC_RST_BYTE;
            host_ien_q <= `IPC_RST_BYTE;
            gen_out_q <= `IPC_RST_BYTE;
        end else if (wr_sel) begin
            case (i_reg_addr)
                `IPC_REG_CPU_CTL: cpu_ctl_q <= i_reg_wdata;
                `IPC_REG_MODE: mode_q <= i_reg_wdata;
                `IPC_REG_IN_EN: in_en_q <= i_reg_wdata;
                `IPC_REG_IN_POL: in_pol_q <= i_reg_wdata;
                `IPC_REG_HOST_IEN: host_ien_q <= i_reg_wdata;
                // low nibble drives outputs; upper bits ignored
                `IPC_REG_IO_LOW: gen_out_q[3:0] <= i_reg_wdata[3:0];
                `IPC_REG_IO_HIGH: gen_out_q[7:4] <= i_reg_wdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // input flags: edge sets, writing one clears, set wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            in_flags_q <= `IPC_RST_BYTE;
        end else if (chip_rst) begin
            in_flags_q <= `IPC_RST_BYTE;
        end else if (wr_sel && i_reg_addr == `IPC_REG_IN_FLAGS) begin
            in_flags_q <= (in_flags_q & ~i_reg_wdata) | in_edge;
        end else begin
            in_flags_q <= in_flags_q | in_edge;
        end
    end

    // host flags: attach change sets, writing one clears, set wins
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            host_irq_q <= `IPC_RST_BYTE;
        end else if (chip_rst) begin
            host_irq_q <= `IPC_RST_BYTE;
        end else begin
            if (wr_sel && i_reg_addr == `IPC_REG_HOST_IRQ) begin
                host_irq_q[`IPC_BIT_ATTACH_CHG] <= (host_irq_q[`IPC_BIT_ATTACH_CHG]
                    & ~i_reg_wdata[`IPC_BIT_ATTACH_CHG]) | attach_chg;
            end else begin
                host_irq_q[`IPC_BIT_ATTACH_CHG] <= host_irq_q[`IPC_BIT_ATTACH_CHG]
                    | attach_chg;
            end
        end
    end

    // edge history; reloaded during chip reset so release makes no edge
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            gen_in_prev_q <= 8'h00;
            attach_prev_q <= 1'b0;
        end else begin
            gen_in_prev_q <= gen_in_s;
            attach_prev_q <= attach_s;
        end
    end

    // ready indicator: high once both resets are gone
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            operate_q <= 1'b0;
        end else begin
            operate_q <= chip_reset_n_s;
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        case (i_reg_addr)
            `IPC_REG_BUS_CTL: rd_mux = bus_ctl_q;
            `IPC_REG_CPU_CTL: rd_mux = cpu_ctl_q;
            `IPC_REG_PIN_CFG: rd_mux = pin_cfg_q;
            // inputs in bits 7..4; outputs from the register
            `IPC_REG_IO_LOW: rd_mux = {gen_in_s[3:0], gen_out_q[3:0]};
            `IPC_REG_IO_HIGH: rd_mux = {gen_in_s[7:4], gen_out_q[7:4]};
            `IPC_REG_IN_FLAGS: rd_mux = in_flags_q;
            `IPC_REG_IN_EN: rd_mux = in_en_q;
            `IPC_REG_IN_POL: rd_mux = in_pol_q;
            `IPC_REG_HOST_IRQ: rd_mux = host_irq_q;
            `IPC_REG_HOST_IEN: rd_mux = host_ien_q;
            `IPC_REG_MODE: rd_mux = mode_q;
            default: rd_mux = 8'h00;
        endcase
    end

    // read data stage, one cycle after the address
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata_q <= 8'h00;
        end else begin
            o_reg_rdata_q <= rd_mux;
        end
    end

    // aux pin mux, registered; push-pull except level irq use
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_aux_out_q <= 1'b0;
            o_aux_oe_q <= 1'b1;
        end else begin
            case (aux_sel)
                2'h0: begin
                    o_aux_out_q <= operate_q;
                    o_aux_oe_q <= 1'b1;
                end
                2'h1: begin
                    o_aux_out_q <= bus_power_detected;
                    o_aux_oe_q <= 1'b1;
                end
                2'h2: begin
                    // aux irq pin when split, else bus activity; level mode releases it
                    o_aux_out_q <= split_on ? aux_irq_pin : i_bus_activity;
                    o_aux_oe_q <= split_on ? aux_irq_oe : 1'b1;
                end
                default: begin
                    o_aux_out_q <= i_sof_wave;
                    o_aux_oe_q <= 1'b1;
                end
            endcase
        end
    end

    // transceiver switches and general outputs
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_dplus_pullup_q <= 1'b0;
            o_dplus_pulldown_en_q <= 1'b0;
            o_dminus_pulldown_en_q <= 1'b0;
            o_gen_outputs_q <= 8'h00;
        end else begin
            // pull-up gate from connect, gating and detector
            o_dplus_pullup_q <= bus_ctl_q[`IPC_BIT_CONNECT]
                & (~bus_ctl_q[`IPC_BIT_PWR_GATING] | bus_power_detected);
            // pull-downs follow their own mode bits
            o_dplus_pulldown_en_q <= mode_q[`IPC_BIT_DPLUS_PD];
            o_dminus_pulldown_en_q <= mode_q[`IPC_BIT_DMINUS_PD];
            o_gen_outputs_q <= gen_out_q;
        end
    end
endmodule

/* File: common/ipc_cfg.svh */
`ifndef IPC_CFG_SVH
`define IPC_CFG_SVH

// register indices on the internal register port
`define IPC_REG_BUS_CTL 5'h0f
`define IPC_REG_CPU_CTL 5'h10
`define IPC_REG_PIN_CFG 5'h11
`define IPC_REG_IO_LOW 5'h14
`define IPC_REG_IO_HIGH 5'h15
`define IPC_REG_IN_FLAGS 5'h16
`define IPC_REG_IN_EN 5'h17
`define IPC_REG_IN_POL 5'h18
`define IPC_REG_HOST_IRQ 5'h19
`define IPC_REG_HOST_IEN 5'h1a
`define IPC_REG_MODE 5'h1b

// bus control fields
`define IPC_BIT_CONNECT 3
`define IPC_BIT_PWR_GATING 6
// host cpu control fields
`define IPC_BIT_IRQ_OUT_EN 0
`define IPC_BIT_WIDTH_LO 6
`define IPC_BIT_WIDTH_HI 7
// pin configuration fields
`define IPC_BIT_AUX_SEL_LO 0
`define IPC_BIT_AUX_SEL_HI 1
`define IPC_BIT_ACTIVE_HIGH 2
`define IPC_BIT_LEVEL_MODE 3
// mode fields
`define IPC_BIT_HOST 0
`define IPC_BIT_SPLIT_IRQ 4
`define IPC_BIT_DPLUS_PD 6
`define IPC_BIT_DMINUS_PD 7
// host interrupt fields
`define IPC_BIT_ATTACH_CHG 5

// reset values
`define IPC_RST_BYTE 8'h00

// timing: clock period and edge-mode pulse widths, in ns
`define IPC_CLK_PERIOD_NS 100
`define IPC_PW_SEL0_NS 10600
`define IPC_PW_SEL1_NS 5300
`define IPC_PW_SEL2_NS 2600
`define IPC_PW_SEL3_NS 1300
// nearest whole cycle count for a width in ns
`define IPC_NS_TO_CYC(ns) (((ns) + (`IPC_CLK_PERIOD_NS / 2)) / `IPC_CLK_PERIOD_NS)

`endif

/* File: common/ipc_pkg.sv */
package ipc_pkg;
    // edge-mode pulse generator states, one-hot
    typedef enum logic [1:0] {
        ipc_st_idle = 2'b01,
        ipc_st_pulse = 2'b10
    } ipc_pulse_st_t;
    // pulse width select code
    typedef logic [1:0] ipc_width_sel_t;
    // auxiliary output select code
    typedef logic [1:0] ipc_aux_sel_t;
endpackage

/* File: common/ipc_irq_cfg_if.sv */
`timescale 1ns/1ps
// shared interrupt pin shaping settings, one source, many drivers
interface ipc_irq_cfg_if;
    logic enable;
    logic level_mode;
    logic active_high;
    ipc_pkg::ipc_width_sel_t width_sel;
    modport ctrl (output enable, output level_mode, output active_high, output width_sel);
    modport drv (input enable, input level_mode, input active_high, input width_sel);
endinterface

/* File: rtl/ipc_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser per bit for pin inputs
module ipc_sync #(
    parameter int W = 1
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic [W-1:0] i_async,
    output logic [W-1:0] o_sync_q
);
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_bit
            logic meta_q; // first stage, read only by the second
            always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
                if (i_sys_rst) begin
                    meta_q <= 1'b0;
                    o_sync_q[g] <= 1'b0;
                end else begin
                    meta_q <= i_async[g];
                    o_sync_q[g] <= meta_q;
                end
            end
        end
    endgenerate
endmodule

/* File: rtl/ipc_irq_pin_drv.sv */
`timescale 1ns/1ps
`include "ipc_cfg.svh"
// shapes a request vector into a level or pulsed interrupt pin
module ipc_irq_pin_drv #(
    parameter int N = 1
) (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_soft_rst,
    ipc_irq_cfg_if.drv cfg,
    input wire logic [N-1:0] i_req,
    output logic o_pin_q,
    output logic o_oe_q
);
    import ipc_pkg::*;

    logic [N-1:0] req_prev_q; // request vector one cycle ago
    ipc_pulse_st_t st_q; // pulse generator state
    logic [7:0] cnt_q; // cycles left in the pulse
    logic new_req; // some request just became active
    logic clr_rem; // some request cleared, others still pending
    logic evt; // a pulse is owed
    logic [7:0] width_cyc; // pulse length for current select

    assign new_req = |(i_req & ~req_prev_q);
    assign clr_rem = (|(req_prev_q & ~i_req)) & (|i_req);
    assign evt = new_req | clr_rem;

    // width select to nearest cycle count
    always_comb begin
        case (cfg.width_sel)
            2'h0: width_cyc = 8'(`IPC_NS_TO_CYC(`IPC_PW_SEL0_NS));
            2'h1: width_cyc = 8'(`IPC_NS_TO_CYC(`IPC_PW_SEL1_NS));
            2'h2: width_cyc = 8'(`IPC_NS_TO_CYC(`IPC_PW_SEL2_NS));
            default: width_cyc = 8'(`IPC_NS_TO_CYC(`IPC_PW_SEL3_NS));
        endcase
    end

    // history of the request vector
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            req_prev_q <= '0;
        end else if (i_soft_rst) begin
            req_prev_q <= '0;
        end else begin
            req_prev_q <= i_req;
        end
    end

    // pulse generator; events during a pulse are merged into it
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            st_q <= ipc_st_idle;
            cnt_q <= 8'h00;
        end else if (i_soft_rst || !cfg.enable || cfg.level_mode) begin
            st_q <= ipc_st_idle;
            cnt_q <= 8'h00;
        end else begin
            case (st_q)
                ipc_st_idle: begin
                    if (evt) begin
                        st_q <= ipc_st_pulse;
                        cnt_q <= width_cyc - 8'h01;
                    end
                end
                ipc_st_pulse: begin
                    if (cnt_q == 8'h00) begin
                        st_q <= ipc_st_idle;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    st_q <= ipc_st_idle;
                end
            endcase
        end
    end

    // pin stage: open-drain low in level mode, push-pull in edge mode
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_pin_q <= 1'b1;
            o_oe_q <= 1'b0;
        end else if (cfg.level_mode) begin
            o_pin_q <= 1'b0;
            o_oe_q <= cfg.enable & (|i_req) & ~i_soft_rst;
        end else begin
            o_oe_q <= 1'b1;
            o_pin_q <= (st_q == ipc_st_pulse) ? cfg.active_high : ~cfg.active_high;
        end
    end
endmodule

/* File: tb/ipc_pin_ctrl_props.sv */
`timescale 1ns/1ps
module ipc_pin_ctrl_props (
    input wire logic i_core_clk,
    input wire logic i_sys_rst,
    input wire logic i_chip_reset_n,
    input wire logic [4:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic [7:0] o_reg_rdata_q,
    input wire logic [7:0] o_gen_outputs_q,
    input wire logic i_sof_wave,
    input wire logic o_irq_pin_q,
    input wire logic o_irq_oe_q,
    input wire logic o_aux_out_q,
    input wire logic o_dplus_pullup_q,
    input wire logic o_dplus_pulldown_en_q,
    input wire logic o_dminus_pulldown_en_q
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);
    // cycles since chip reset let go, past the synchroniser
    logic [2:0] up_q;
    // shadows of registers kept over chip reset
    logic [7:0] bc_q;
    logic [7:0] pc_q;
    // settle counter
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) up_q <= 3'h0;
        else if (!i_chip_reset_n) up_q <= 3'h0;
        else if (up_q != 3'h7) up_q <= up_q + 3'h1;
    end
    // register shadows, writable even in chip reset
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) bc_q <= 8'h00;
        else if (i_reg_wr && i_reg_addr == 5'h0f) bc_q <= i_reg_wdata;
    end
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) pc_q <= 8'h00;
        else if (i_reg_wr && i_reg_addr == 5'h11) pc_q <= i_reg_wdata;
    end
    chk_pullup_connect: assert property (
        !bc_q[6] && $stable(bc_q) |=> o_dplus_pullup_q == $past(bc_q[3]))
        else $error("pull-up does not follow connect");
    chk_gpout_low: assert property (
        up_q == 3'h7 && i_reg_wr && i_reg_addr == 5'h14
        |-> ##2 o_gen_outputs_q[3:0] == $past(i_reg_wdata[3:0], 2))
        else $error("low outputs not written");
    chk_gpout_high: assert property (
        up_q == 3'h7 && i_reg_wr && i_reg_addr == 5'h15
        |-> ##2 o_gen_outputs_q[7:4] == $past(i_reg_wdata[3:0], 2))
        else $error("high outputs not written");
    chk_dp_pulldown: assert property (
        up_q == 3'h7 && i_reg_wr && i_reg_addr == 5'h1b
        |-> ##2 o_dplus_pulldown_en_q == $past(i_reg_wdata[6], 2))
        else $error("d plus pull-down wrong");
    chk_dm_pulldown: assert property (
        up_q == 3'h7 && i_reg_wr && i_reg_addr == 5'h1b
        |-> ##2 o_dminus_pulldown_en_q == $past(i_reg_wdata[7], 2))
        else $error("d minus pull-down wrong");
    chk_irq_quiet: assert property (
        up_q == 3'h7 && i_reg_wr && i_reg_addr == 5'h10 && !i_reg_wdata[0]
        ##1 !i_reg_wr [*3] |=> $stable(o_irq_pin_q) && $stable(o_irq_oe_q))
        else $error("interrupt pin moved while disabled");
    chk_aux_frame: assert property (
        pc_q[1:0] == 2'b11 && $past(pc_q[1:0]) == 2'b11
        |=> o_aux_out_q == $past(i_sof_wave))
        else $error("aux does not show frame wave");
    chk_unmapped_zero: assert property (
        i_reg_addr == 5'h13 |=> o_reg_rdata_q == 8'h00)
        else $error("unmapped read not zero");
endmodule
bind ipc_pin_ctrl ipc_pin_ctrl_props ipc_pin_ctrl_props_inst (.i_core_clk, .i_sys_rst,
    .i_chip_reset_n, .i_reg_addr, .i_reg_wr, .i_reg_wdata, .o_reg_rdata_q, .o_gen_outputs_q,
    .i_sof_wave, .o_irq_pin_q, .o_irq_oe_q, .o_aux_out_q, .o_dplus_pullup_q,
    .o_dplus_pulldown_en_q, .o_dminus_pulldown_en_q);

/* File: tb/ipc_host_model.sv */
`timescale 1ns/1ps
// register master; drives just after a rising edge
module ipc_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_reg_rdata,
    output logic [4:0] o_reg_addr,
    output logic o_reg_wr,
    output logic [7:0] o_reg_wdata
);
    initial begin
        o_reg_addr = 5'h00;
        o_reg_wr = 1'b0;
        o_reg_wdata = 8'h00;
    end
    // one write, strobe up for one edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge i_core_clk) #1;
        o_reg_addr = a;
        o_reg_wdata = d;
        o_reg_wr = 1'b1;
        @(posedge i_core_clk) #1;
        o_reg_wr = 1'b0;
        // poison stale data
        o_reg_wdata = ~d;
    endtask
    // one read, data one edge after the index
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_core_clk) #1;
        o_reg_addr = a;
        @(posedge i_core_clk) #1;
        d = i_reg_rdata;
    endtask
endmodule

/* File: tb/test_ipc_pin_ctrl.sv */
`timescale 1ns/1ps
module test_ipc_pin_ctrl;
    logic i_core_clk = 1'b0, i_sys_rst = 1'b1, i_chip_reset_n = 1'b1, i_reg_wr;
    logic [4:0] i_reg_addr;
    logic [7:0] i_reg_wdata, o_reg_rdata_q, i_gen_inputs = 8'h00, o_gen_outputs_q, d, v, w;
    logic i_bus_power_sense_in = 1'b0, i_attach_det = 1'b0, i_bus_activity = 1'b0;
    logic i_sof_wave = 1'b0, i_core_irq_req = 1'b0, o_irq_pin_q, o_irq_oe_q, o_aux_out_q;
    logic o_dplus_pullup_q, o_dplus_pulldown_en_q, o_dminus_pulldown_en_q, o_aux_oe_q;
    logic [31:0] lfsr = 32'h81cfa3f3;
    // notes of expected results, and what was seen
    logic [7:0] exp_q[$], got_q[$], me, mg;
    string nm_q[$];
    event seen;
    int n_fail = 0, compares = 0, n;
    logic [7:0] widths[4] = '{8'h6a, 8'h35, 8'h1a, 8'h0d};
    logic [4:0] regs[6] = '{5'h10, 5'h11, 5'h13, 5'h17, 5'h18, 5'h1b};
    ipc_pin_ctrl ipc_pin_ctrl_inst (.*);
    ipc_host_model ipc_host_model_inst (.i_core_clk, .i_reg_rdata(o_reg_rdata_q),
        .o_reg_addr(i_reg_addr), .o_reg_wr(i_reg_wr), .o_reg_wdata(i_reg_wdata));
    initial begin
        forever #50 i_core_clk = ~i_core_clk;
    end
    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // background noise on frame wave and bus activity
    always @(posedge i_core_clk) begin
        #1;
        lfsr = lfsr_next(lfsr);
        i_sof_wave = lfsr[3];
        i_bus_activity = lfsr[9];
    end
    task automatic finish_test;
        #1;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic note(input string nm, input logic [7:0] e, input logic [7:0] g);
        nm_q.push_back(nm);
        exp_q.push_back(e);
        got_q.push_back(g);
        ->seen;
    endtask
    // compare each result against the oldest note
    initial forever begin
        @seen;
        while (got_q.size() > 0) begin
            me = exp_q.pop_front();
            mg = got_q.pop_front();
            compares++;
            if (me !== mg) begin
                $display("wrong value %s expected %h seen %h", nm_q[0], me, mg);
                n_fail++;
            end
            void'(nm_q.pop_front());
        end
    end
    task automatic cyc(input int k);
        repeat (k) @(posedge i_core_clk);
        #1;
    endtask
    // short forms of the far-side bus tasks
    task automatic wr(input logic [4:0] a, input logic [7:0] x);
        ipc_host_model_inst.wr(a, x);
    endtask
    task automatic rd(input logic [4:0] a);
        ipc_host_model_inst.rd(a, d);
    endtask
    // bounded wait for {oe, pin}
    task automatic wait_irq(input logic [1:0] want);
        int k;
        k = 0;
        while ({o_irq_oe_q, o_irq_pin_q} !== want && k < 20) begin
            cyc(1);
            k++;
        end
        note("irq pin", {6'h00, want}, {6'h00, o_irq_oe_q, o_irq_pin_q});
        if (k == 20) finish_test();
    endtask
    initial begin
        repeat (60000) @(posedge i_core_clk);
        n_fail++;
        finish_test();
    end
    initial begin
        cyc(10);
        i_sys_rst = 1'b0;
        cyc(8);
        wr(5'h13, 8'hff);
        foreach (regs[i]) begin
            rd(regs[i]);
            note("reset value", 8'h00, d);
        end
        for (int i = 0; i < 8; i++) begin
            i_bus_power_sense_in = i[0];
            wr(5'h0f, {1'b0, i[1], 2'b00, i[2], 3'b000});
            cyc(6);
            note("pull-up", {7'h00, i[2] & (~i[1] | i[0])}, {7'h00, o_dplus_pullup_q});
        end
        for (int j = 1; j < 4; j++) begin
            wr(5'h1b, {j[1:0], 6'h00});
            cyc(3);
            note("pulldn", j[7:0], {6'h00, o_dminus_pulldown_en_q, o_dplus_pulldown_en_q});
        end
        wr(5'h1b, 8'h00);
        for (int j = 0; j < 3; j++) begin
            v = lfsr[7:0];
            w = lfsr[15:8];
            i_gen_inputs = lfsr[31:24];
            wr(5'h14, v);
            wr(5'h15, w);
            cyc(4);
            note("outputs", {w[3:0], v[3:0]}, o_gen_outputs_q);
            rd(5'h14);
            note("io low", {i_gen_inputs[3:0], v[3:0]}, d);
            rd(5'h15);
            note("io high", {i_gen_inputs[7:4], w[3:0]}, d);
        end
        i_gen_inputs = 8'h00;
        cyc(4);
        wr(5'h16, 8'hff);
        wr(5'h17, 8'h01);
        wr(5'h18, 8'h01);
        wr(5'h11, 8'h04);
        for (int s = 0; s < 4; s++) begin
            wr(5'h10, {s[1:0], 6'h01});
            i_gen_inputs[0] = 1'b1;
            wait_irq(2'b11);
            n = 0;
            while (o_irq_pin_q === 1'b1 && n < 200) begin
                cyc(1);
                n++;
            end
            note("pulse width", widths[s], n[7:0]);
            i_gen_inputs[0] = 1'b0;
            wr(5'h16, 8'h01);
            cyc(4);
        end
        i_core_irq_req = 1'b1;
        wait_irq(2'b11);
        wait_irq(2'b10);
        i_gen_inputs[0] = 1'b1;
        wait_irq(2'b11);
        wait_irq(2'b10);
        wr(5'h16, 8'h01);
        wait_irq(2'b11);
        wait_irq(2'b10);
        wr(5'h10, 8'h00);
        i_core_irq_req = 1'b0;
        cyc(3);
        i_core_irq_req = 1'b1;
        cyc(5);
        note("irq off", 8'h02, {6'h00, o_irq_oe_q, o_irq_pin_q});
        i_core_irq_req = 1'b0;
        i_gen_inputs[0] = 1'b0;
        wr(5'h16, 8'hff);
        wr(5'h11, 8'h0c);
        wr(5'h10, 8'h01);
        i_gen_inputs[0] = 1'b1;
        wait_irq(2'b10);
        i_core_irq_req = 1'b1;
        wr(5'h16, 8'h01);
        cyc(4);
        note("level held", 8'h02, {6'h00, o_irq_oe_q, o_irq_pin_q});
        i_core_irq_req = 1'b0;
        cyc(4);
        note("level release", 8'h00, {7'h00, o_irq_oe_q});
        i_gen_inputs[0] = 1'b0;
        wr(5'h1b, 8'h10);
        wr(5'h11, 8'h0a);
        i_gen_inputs[0] = 1'b1;
        cyc(6);
        note("main split", 8'h00, {7'h00, o_irq_oe_q});
        note("aux irq", 8'h00, {7'h00, o_aux_out_q});
        note("aux oe", 8'h01, {7'h00, o_aux_oe_q});
        wr(5'h11, 8'h03);
        cyc(6);
        wr(5'h11, 8'h01);
        cyc(5);
        note("aux power", 8'h01, {7'h00, o_aux_out_q});
        wr(5'h17, 8'hff);
        wr(5'h11, 8'h04);
        i_chip_reset_n = 1'b0;
        cyc(5);
        note("aux operate", 8'h00, {7'h00, o_aux_out_q});
        i_chip_reset_n = 1'b1;
        cyc(8);
        note("aux operate", 8'h01, {7'h00, o_aux_out_q});
        rd(5'h17);
        note("chip reset", 8'h00, d);
        rd(5'h11);
        note("pin config kept", 8'h04, d);
        wr(5'h1b, 8'h01);
        i_attach_det = 1'b1;
        cyc(5);
        rd(5'h19);
        note("attach", 8'h20, d);
        wr(5'h19, 8'h20);
        rd(5'h19);
        note("attach clear", 8'h00, d);
        finish_test();
    end
endmodule
